// *** dv/pasl_mgmt.sv ***
`timescale 1ns/1ps
module pasl_mgmt (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rdata,
   output logic             o_wr,
   output logic             o_rd,
   output logic [4:0]       o_addr,
   output logic [15:0]      o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 5'h00;
      o_wdata = 16'h0000;
   end
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      // Idle bus shows a changed value, not the last one
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      #1 d = i_rdata;
   endtask : rd
endmodule : pasl_mgmt

// *** dv/pasl_top_sva.sv ***
`timescale 1ns/1ps
module pasl_top_sva
   import pasl_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [4:0]  i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [7:0]  i_irq_event,
   input wire logic [15:0] o_reg_rdata,
   input wire logic [5:0]  o_ind_level,
   input wire logic [5:0]  o_ind_oe,
   input wire logic        o_chip_pwrdn,
   input wire logic        o_sw_pwrdn,
   input wire logic        o_func_enable
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire rd_irq = i_reg_rd && i_reg_addr == 5'h1B && i_irq_event == 8'h00;
   wire wr_pd  = i_reg_wr && i_reg_addr == 5'h00;
   wire mapped = i_reg_addr inside {5'h00, 5'h11, 5'h1B, 5'h1F};
   unmapped_rd_a:
      assert property (i_reg_rd && !mapped |=> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
   rdata_hold_a:
      assert property (!i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
   pwrdn_set_a:
      assert property (wr_pd && i_reg_wdata[11] |=> o_sw_pwrdn) else $error("power-down not entered");
   pwrdn_clr_a:
      assert property (wr_pd && !i_reg_wdata[11] |=> !o_sw_pwrdn) else $error("power-down not left");
   pwrdn_off_a:
      assert property (o_sw_pwrdn |-> !o_func_enable) else $error("functions alive in power-down");
   chip_off_a:
      assert property (o_chip_pwrdn |-> !o_func_enable) else $error("functions alive in chip power-down");
   pullup_high_a:
      assert property ((o_ind_level | o_ind_oe) == 6'h3F) else $error("released indicator not high");
   status_clear_a:
      assert property (rd_irq ##1 (!i_reg_wr && i_irq_event == 8'h00)[*1] ##1 rd_irq |=> o_reg_rdata[7:0] == 8'h00)
         else $error("status not cleared by read");
endmodule : pasl_top_sva
bind pasl_top pasl_top_sva i_sva (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_irq_event(i_irq_event), .o_reg_rdata(o_reg_rdata),
   .o_ind_level(o_ind_level), .o_ind_oe(o_ind_oe), .o_chip_pwrdn(o_chip_pwrdn), .o_sw_pwrdn(o_sw_pwrdn),
   .o_func_enable(o_func_enable));

// *** dv/phy_aux_status_led_power_ctrl_bench.sv ***
`timescale 1ns/1ps
module phy_aux_status_led_power_ctrl_bench
   import pasl_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, c125 = 1'b1, wr, rd, irq_lv, irq_oe, rclk, nmode, cpd, swpd, psave, fen;
   logic [3:0] strap = 4'h1;
   logic [7:0] ev = 8'h00;
   pasl_link_t lnk = '0;
   logic [29:0] nand_in = '1;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, d;
   logic [5:0] ind_lv, ind_oe;
   int fail_count = 0, checks = 0;
   always #2 clk = ~clk;
   pasl_mgmt m (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   pasl_top i_dut (.i_clk(clk), .i_rst(rst), .i_mode_strap(strap), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_irq_event(ev), .i_link(lnk), .i_nand_pins(nand_in),
      .i_clk125_src(c125), .o_reg_rdata(rdata), .o_irq_level(irq_lv), .o_irq_oe(irq_oe), .o_ind_level(ind_lv),
      .o_ind_oe(ind_oe), .o_ref_clk_out_125(rclk), .o_nand_mode(nmode), .o_chip_pwrdn(cpd),
      .o_sw_pwrdn(swpd), .o_power_save(psave), .o_func_enable(fen));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic pulse();
      @(posedge clk) ev <= 8'h01;
      @(posedge clk) ev <= 8'h00;
      cyc(1);
   endtask : pulse
   task automatic do_reset(input logic [3:0] s);
      @(posedge clk) begin
         strap <= s;
         rst <= 1'b1;
      end
      // Synchroniser stays cleared while reset holds; straps pass through it after release
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // Modes settle on the fifth edge after release
      cyc(6);
   endtask : do_reset
   task automatic t_regs();
      logic [4:0] ra[5] = '{5'h00, 5'h11, 5'h1F, 5'h1B, 5'h05};
      logic [15:0] rv[5] = '{16'h1000, 16'h00C0, 16'h0000, 16'h0000, 16'h0000};
      for (int i = 0; i < 5; i++) begin
         m.rd(ra[i], d);
         chk("reg", rv[i], d);
      end
   endtask : t_regs
   task automatic t_irq();
      pulse();
      chk("irq_masked", 16'h3, 16'({irq_oe, irq_lv}));
      m.rd(5'h1B, d);
      chk("status", 16'h0001, d);
      m.wr(5'h1B, 16'h0100);
      pulse();
      chk("irq_low", 16'h2, 16'({irq_oe, irq_lv}));
      m.wr(5'h1F, 16'h4000);
      cyc(1);
      chk("irq_high", 16'h3, 16'({irq_oe, irq_lv}));
      m.rd(5'h1B, d);
      chk("status", 16'h0101, d);
      chk("irq_off", 16'h2, 16'({irq_oe, irq_lv}));
      m.rd(5'h1B, d);
      chk("status", 16'h0100, d);
      m.wr(5'h1F, 16'h0000);
   endtask : t_irq
   task automatic t_layout();
      logic [15:0] lw[5] = '{16'h0080, 16'h0040, 16'h0040, 16'h00C0, 16'h0000};
      logic [1:0] ar[5] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
      logic [5:0] el[5] = '{6'h33, 6'h33, 6'h32, 6'h31, 6'h3F};
      logic [5:0] om[5] = '{6'h03, 6'h02, 6'h02, 6'h00, 6'h3F};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) lnk <= pasl_link_t'({5'b11010, ar[i]});
         // Layout changes live, no reset between rows
         m.wr(5'h11, lw[i]);
         cyc(2);
         chk("ind", {4'h0, el[i], 6'h00}, {4'h0, ind_lv, ind_oe & om[i]});
      end
      m.wr(5'h11, 16'h00C0);
   endtask : t_layout
   task automatic t_power();
      m.wr(5'h00, 16'h1800);
      cyc(2);
      chk("pd", 16'h2, 16'({swpd, fen}));
      chk("pd_oe", 16'h0, 16'(ind_oe));
      m.rd(5'h00, d);
      chk("pd_rd", 16'h1800, d);
      m.wr(5'h00, 16'h1000);
      cyc(2);
      chk("pd", 16'h1, 16'({swpd, fen}));
      @(posedge clk) lnk <= '0;
      cyc(2);
      chk("psave", 16'h1, 16'(psave));
      m.wr(5'h00, 16'h0000);
      cyc(2);
      chk("psave", 16'h0, 16'(psave));
      m.wr(5'h00, 16'h1000);
   endtask : t_power
   task automatic t_strap();
      do_reset(4'h4);
      chk("nand_mode", 16'h1, 16'(nmode));
      cyc(6);
      chk("nand_all", 16'h0, 16'(rclk));
      for (int i = 0; i < 30; i++) begin
         @(posedge clk) nand_in <= ~(30'h1 << i);
         cyc(6);
         chk("nand_bit", 16'h1, 16'(rclk));
      end
      do_reset(4'h7);
      chk("cpd", 16'h2, 16'({cpd, fen}));
      // board reset with an operating strap
      do_reset(4'h1);
      chk("cpd", 16'h1, 16'({cpd, nmode, fen}));
   endtask : t_strap
   task automatic test_done();
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done
   initial begin
      #40000;
      fail_count++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      t_regs();
      t_irq();
      t_layout();
      t_power();
      t_strap();
      test_done();
   end
endmodule : phy_aux_status_led_power_ctrl_bench

// *** hdl/pasl_defs.svh ***
`ifndef PASL_DEFS_SVH
`define PASL_DEFS_SVH
`define PASL_REG_BASIC_CTRL   5'h00
`define PASL_REG_IND_CTRL     5'h11
`define PASL_REG_IRQ          5'h1B
`define PASL_REG_PHY_CTRL     5'h1F
`define PASL_BIT_PWRDN        11
`define PASL_BIT_ANEG_EN      12
`define PASL_BIT_IRQ_POL      14
`define PASL_LAYOUT_HI        7
`define PASL_LAYOUT_LO        6
`define PASL_BASIC_RST        16'h1000
`define PASL_IND_RST          16'h00C0
`define PASL_PHY_RST          16'h0000
`define PASL_IRQ_RST          16'h0000
`define PASL_MODE_NAND        4'h4
`define PASL_MODE_CPD         4'h7
`define PASL_STRAP_WAIT       3'h4
`define PASL_CLK_HZ           250000000
`define PASL_BLINK_MS         80
`define PASL_BLINK_HALF       ((`PASL_CLK_HZ / 1000) * `PASL_BLINK_MS / 2)
`define PASL_NAND_W           30
`endif

// *** hdl/pasl_pkg.sv ***
package pasl_pkg;
   typedef enum logic [1:0] {
      PASL_LAY_RSVD = 2'h0,
      PASL_LAY_FIVE = 2'h1,
      PASL_LAY_FOUR = 2'h2,
      PASL_LAY_SIX  = 2'h3
   } pasl_layout_t;

   typedef struct packed {
      logic       link_up;
      logic [1:0] speed;
      logic       full_duplex;
      logic       collision;
      logic       tx_act;
      logic       rx_act;
   } pasl_link_t;

   typedef struct packed {
      logic [5:0] drive;
      logic [5:0] level;
   } pasl_ind_t;
endpackage : pasl_pkg

// *** hdl/pasl_sync.sv ***
`timescale 1ns/1ps
module pasl_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] out_reg;
   logic [W-1:0] out_next;

   // Change only once second and third stage agree
   assign out_next = (s2_reg == s3_reg) ? s2_reg : out_reg;
   assign o_sync   = out_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         out_reg <= '0;
      end else begin
         s1_reg  <= i_async;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         out_reg <= out_next;
      end
   end
endmodule : pasl_sync

// *** hdl/pasl_top.sv ***
// Contract
// R1: Interrupt only for enabled conditions, bits 15:8
// R2: Status bits 7:0 latch conditions
// R3: Reading register 27 clears status
// R4: Bit 14 of 31 sets polarity
// R5: Bits 7:6 of 17 select layout
// R6: Four-layout: speed pins link/activity, duplex pin
// R7: Four-layout: pins two and one undriven
// R8: Five-layout: link pins, pin one activity
// R9: Five-layout: pin two undriven
// R10: Six-layout: pin two receive, one transmit
// R11: Activity blinks at 80 ms period
// R12: Strap 0100 enters board-test mode
// R13: Test chain of inputs onto clock pin
// R14: Power saving when autoneg, no link
// R15: Write one bit 11 powers down
// R16: Power-down keeps only management alive
// R17: Write zero bit 11 resumes
// R18: Strap 0111 enters chip power-down
// R19: Board resets to leave chip power-down
// R20: Interrupt drops when no enabled pending
// R21: Layout change applies without reset
`timescale 1ns/1ps
`include "pasl_defs.svh"
module pasl_top
   import pasl_pkg::*;
(
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire logic [3:0]              i_mode_strap,
   input  wire logic                    i_reg_wr,
   input  wire logic                    i_reg_rd,
   input  wire logic [4:0]              i_reg_addr,
   input  wire logic [15:0]             i_reg_wdata,
   input  wire logic [7:0]              i_irq_event,
   input  wire pasl_link_t              i_link,
   input  wire logic [`PASL_NAND_W-1:0] i_nand_pins,
   input  wire logic                    i_clk125_src,
   output logic [15:0]                  o_reg_rdata,
   output logic                         o_irq_level,
   output logic                         o_irq_oe,
   output logic [5:0]                   o_ind_level,
   output logic [5:0]                   o_ind_oe,
   output logic                         o_ref_clk_out_125,
   output logic                         o_nand_mode,
   output logic                         o_chip_pwrdn,
   output logic                         o_sw_pwrdn,
   output logic                         o_power_save,
   output logic                         o_func_enable
);
   logic [15:0]             basic_reg;
   logic [15:0]             basic_next;
   logic [15:0]             ind_reg;
   logic [15:0]             ind_next;
   logic [15:0]             phy_reg;
   logic [15:0]             phy_next;
   logic [7:0]              irq_en_reg;
   logic [7:0]              irq_en_next;
   logic [7:0]              irq_st_reg;
   logic [7:0]              irq_st_next;
   logic [15:0]             rdata_reg;
   logic [15:0]             rdata_next;
   logic [2:0]              strap_wait_reg;
   logic                    strap_take;
   logic [3:0]              strap_reg;
   logic                    nand_reg;
   logic                    cpd_reg;
   logic [31:0]             blink_cnt_reg;
   logic [31:0]             blink_cnt_next;
   logic                    blink_reg;
   logic                    blink_wrap;
   logic [5:0]              ind_lvl_reg;
   logic [5:0]              ind_oe_reg;
   pasl_ind_t               ind_now;
   pasl_layout_t            layout;
   logic [3:0]              strap_sync;
   logic [`PASL_NAND_W-1:0] nand_sync;
   logic                    nand_chain;
   logic                    irq_active;
   logic                    irq_pol_high;
   logic                    sel_basic;
   logic                    sel_ind;
   logic                    sel_phy;
   logic                    sel_irq;
   logic                    active;
   logic [2:0]              spd_on;
   logic                    act_any;
   logic                    pin_three;
   logic [2:0]              spd_pins;

   pasl_sync #(.W(4)) u_strap_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_mode_strap),
      .o_sync  (strap_sync)
   );

   pasl_sync #(.W(`PASL_NAND_W)) u_nand_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_nand_pins),
      .o_sync  (nand_sync)
   );

   assign sel_basic = (i_reg_addr == `PASL_REG_BASIC_CTRL);
   assign sel_ind   = (i_reg_addr == `PASL_REG_IND_CTRL);
   assign sel_phy   = (i_reg_addr == `PASL_REG_PHY_CTRL);
   assign sel_irq   = (i_reg_addr == `PASL_REG_IRQ);

   assign basic_next  = (i_reg_wr && sel_basic) ? i_reg_wdata : basic_reg;
   // R5 Layout field storage
   assign ind_next    = (i_reg_wr && sel_ind) ? i_reg_wdata : ind_reg;
   assign phy_next    = (i_reg_wr && sel_phy) ? i_reg_wdata : phy_reg;
   assign irq_en_next = (i_reg_wr && sel_irq) ? i_reg_wdata[15:8] : irq_en_reg;
   // R2 Latch conditions, set beats clear
   // R3 Read clears status
   assign irq_st_next = ((i_reg_rd && sel_irq) ? 8'h00 : irq_st_reg) | i_irq_event;

   always_comb begin
      rdata_next = 16'h0000;
      if (sel_basic) begin
         rdata_next = basic_reg;
      end else if (sel_ind) begin
         rdata_next = ind_reg;
      end else if (sel_phy) begin
         rdata_next = phy_reg;
      end else if (sel_irq) begin
         rdata_next = {irq_en_reg, irq_st_reg};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         basic_reg  <= `PASL_BASIC_RST;
         ind_reg    <= `PASL_IND_RST;
         phy_reg    <= `PASL_PHY_RST;
         {irq_en_reg, irq_st_reg} <= `PASL_IRQ_RST;
         rdata_reg  <= 16'h0000;
      end else begin
         basic_reg  <= basic_next;
         ind_reg    <= ind_next;
         phy_reg    <= phy_next;
         irq_en_reg <= irq_en_next;
         irq_st_reg <= irq_st_next;
         rdata_reg  <= i_reg_rd ? rdata_next : rdata_reg;
      end
   end
   assign o_reg_rdata = rdata_reg;

   // Straps caught once, after the cleared synchroniser has refilled
   assign strap_take = (strap_wait_reg == `PASL_STRAP_WAIT);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         strap_wait_reg <= 3'h0;
      end else if (strap_wait_reg <= `PASL_STRAP_WAIT) begin
         strap_wait_reg <= strap_wait_reg + 3'h1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         strap_reg      <= 4'h0;
         nand_reg       <= 1'b0;
         cpd_reg        <= 1'b0;
      end else if (strap_take) begin
         strap_reg      <= strap_sync;
         // R12 Board-test strap
         nand_reg       <= (strap_sync == `PASL_MODE_NAND);
         // R18 Chip power-down strap
         cpd_reg        <= (strap_sync == `PASL_MODE_CPD);
      end
   end
   // Sync chain is cleared by reset and needs four edges to refill;
   // modes are known from the fifth edge after release.
   // R19 Only reset leaves chip power-down
   assign o_chip_pwrdn = cpd_reg;
   assign o_nand_mode  = nand_reg;

   // R15 Power-down on bit 11 set
   // R17 Resume on bit 11 cleared
   assign o_sw_pwrdn    = basic_reg[`PASL_BIT_PWRDN];
   // R16 Everything but management stops
   assign active        = ~o_sw_pwrdn & ~cpd_reg & ~nand_reg;
   assign o_func_enable = active;
   // R14 Saving when autoneg on, no link
   assign o_power_save  = active & basic_reg[`PASL_BIT_ANEG_EN] & ~i_link.link_up;

   // R11 Half period of 40 ms toggle
   assign blink_wrap     = (blink_cnt_reg == 32'(`PASL_BLINK_HALF - 1));
   assign blink_cnt_next = blink_wrap ? 32'h0 : blink_cnt_reg + 32'h1;
   always_ff @(posedge i_clk) begin
      if (i_rst || !active) begin
         blink_cnt_reg <= 32'h0;
         blink_reg     <= 1'b0;
      end else begin
         blink_cnt_reg <= blink_cnt_next;
         blink_reg     <= blink_wrap ? ~blink_reg : blink_reg;
      end
   end

   // R21 Layout read live from the register
   assign layout = pasl_layout_t'(ind_reg[`PASL_LAYOUT_HI:`PASL_LAYOUT_LO]);
   assign spd_on[0] = i_link.link_up && (i_link.speed == 2'h0);
   assign spd_on[1] = i_link.link_up && (i_link.speed == 2'h1);
   assign spd_on[2] = i_link.link_up && (i_link.speed == 2'h2);
   assign act_any   = i_link.tx_act | i_link.rx_act;
   // Duplex low when full, blink on collision
   assign pin_three = i_link.collision ? blink_reg : ~i_link.full_duplex;

   always_comb begin
      spd_pins = ~spd_on;
      ind_now  = '{drive: 6'h00, level: 6'h3F};
      case (layout)
         PASL_LAY_FOUR: begin
            // R6 Combined link and activity per speed
            spd_pins = ~spd_on | ({3{act_any & blink_reg}} & spd_on);
            // R7 Pins two and one released
            ind_now  = '{drive: 6'h3C, level: {spd_pins[0], spd_pins[1], spd_pins[2], pin_three, 2'h3}};
         end
         PASL_LAY_FIVE: begin
            // R8 Link-only pins, activity on pin one
            // R9 Pin two released
            ind_now = '{drive: 6'h3D,
                        level: {spd_pins[0], spd_pins[1], spd_pins[2], pin_three, 1'b1,
                                ~(act_any & ~blink_reg)}};
         end
         PASL_LAY_SIX: begin
            // R10 Receive on two, transmit on one
            ind_now = '{drive: 6'h3F,
                        level: {spd_pins[0], spd_pins[1], spd_pins[2], pin_three,
                                ~(i_link.rx_act & ~blink_reg), ~(i_link.tx_act & ~blink_reg)}};
         end
         default: begin
            ind_now = '{drive: 6'h00, level: 6'h3F};
         end
      endcase
   end

   // Indicators quiet while any power-down or test mode holds
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ind_lvl_reg <= 6'h3F;
         ind_oe_reg  <= 6'h00;
      end else begin
         ind_lvl_reg <= active ? ind_now.level : 6'h3F;
         ind_oe_reg  <= active ? ind_now.drive : 6'h00;
      end
   end
   assign o_ind_level = ind_lvl_reg;
   assign o_ind_oe    = ind_oe_reg;

   // R1 Only enabled conditions raise it
   // R20 Drops once no enabled bit pending
   assign irq_active   = |(irq_en_reg & irq_st_reg);
   // R4 Polarity from bit 14, default low
   assign irq_pol_high = phy_reg[`PASL_BIT_IRQ_POL];
   assign o_irq_level  = irq_pol_high ? irq_active : ~irq_active;
   assign o_irq_oe     = active;

   // R13 NAND chain, first input at bit zero
   assign nand_chain = ~(&nand_sync);
   assign o_ref_clk_out_125 = nand_reg ? nand_chain : (active & i_clk125_src);
endmodule : pasl_top
